// ===== core/rtc_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
`define RTC_SEC         6'h00
`define RTC_SEC_ALM     6'h01
`define RTC_MIN         6'h02
`define RTC_MIN_ALM     6'h03
`define RTC_HOUR        6'h04
`define RTC_HOUR_ALM    6'h05
`define RTC_DOW         6'h06
`define RTC_DATE        6'h07
`define RTC_MONTH       6'h08
`define RTC_YEAR        6'h09
`define RTC_REG_A       6'h0a
`define RTC_REG_B       6'h0b
`define RTC_REG_C       6'h0c
`define RTC_REG_D       6'h0d
`define RTC_A_UIP       7
`define RTC_B_SET       7
`define RTC_B_AIE       5
`define RTC_B_UIE       4
`define RTC_B_DM        2
`define RTC_B_H24       1
`define RTC_C_INTERRUPT_SUMMARY_FLAG      7
`define RTC_C_AF        5
`define RTC_C_UF        4
`define RTC_D_VRT       7
`define RTC_DV_SLOW     3'h2
`define RTC_DV_HELD     2'h3
`define RTC_WILD        2'h3
`define RTC_A_RST       8'h00
`define RTC_B_RST       8'h02
`define RTC_RESP_OKAY   2'h0
`define RTC_RESP_SLVERR 2'h2
`define RTC_CLK_NS      25
`define RTC_SEC_NS      1000000000
`define RTC_WIN_FAST_US 248
`define RTC_WIN_SLOW_US 1948
`define RTC_IRQ_REL_NS  2000
`define RTC_SEC_CYC     (`RTC_SEC_NS / `RTC_CLK_NS)
`define RTC_WIN_FAST_CYC ((`RTC_WIN_FAST_US * 1000) / `RTC_CLK_NS)
`define RTC_WIN_SLOW_CYC ((`RTC_WIN_SLOW_US * 1000) / `RTC_CLK_NS)
`define RTC_IRQ_REL_CYC (`RTC_IRQ_REL_NS / `RTC_CLK_NS)
`endif

// ===== core/rtc_pkg.sv
// Types and number-format helpers shared by the timekeeping files.
package rtc_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [8:0] axi_addr_t;
	typedef logic [1:0] resp_t;

	// Turns a stored byte into a plain count, from BCD when asked.
	function automatic logic [6:0] to_bin(input byte_t v, input logic bcd);
		logic [6:0] r;
		r = bcd ? 7'({3'h0, v[7:4]} * 7'd10 + {3'h0, v[3:0]}) : v[6:0];
		return r;
	endfunction : to_bin

	// Turns a plain count back into the stored format.
	function automatic byte_t from_bin(input logic [6:0] b, input logic bcd);
		logic [6:0] t;
		logic [6:0] o;
		t = 7'(b / 7'd10);
		o = 7'(b % 7'd10);
		return bcd ? {t[3:0], o[3:0]} : {1'b0, b};
	endfunction : from_bin
endpackage : rtc_pkg

// ===== core/rtc_field_step.sv
// One wrapping time or calendar field with carry in and carry out.
module rtc_field_step (
	input  wire logic          bcd_in,
	input  wire rtc_pkg::byte_t val_in,
	input  wire logic [6:0]    lo_in,
	input  wire logic [6:0]    hi_in,
	input  wire logic          carry_in,
	output rtc_pkg::byte_t     next_out,
	output logic               carry_out
);
	import rtc_pkg::*;

	logic [6:0] cur; // Field value as a plain count.

	// Steps only on a carry; the top value wraps back to the low value.
	always_comb begin
		cur = to_bin(val_in, bcd_in);
		carry_out = carry_in && (cur >= hi_in);
		if (!carry_in) begin
			next_out = val_in;
		end else if (cur >= hi_in) begin
			next_out = from_bin(lo_in, bcd_in);
		end else begin
			next_out = from_bin(7'(cur + 7'd1), bcd_in);
		end
	end
endmodule : rtc_field_step

// ===== core/rtc_timekeeping_core.sv
// Time-of-day clock with 64-byte map, reached over AXI4-Lite.
// Contract
// - Latch strobe level while address strobe high.
// - Present 64 bytes: RAM, time, control.
// - Control C, D, A bit 7 read-only.
// - Seconds top bit always reads zero.
// - Update-inhibit bit freezes time and calendar.
// - Increments follow the selected data format.
// - Hour format bit selects 12 or 24.
// - In 12-hour mode top bit means PM.
// - Once a second advance time, check alarm.
// - Update window 248 or 1948 microseconds.
// - Alarm flag when hours, minutes, seconds match.
// - Alarm byte C0 to FF matches anything.
// - Wildcards give hourly, minutely, per-second alarms.
// - Reading control D sets the valid flag.
// - Interrupt released within 2 microseconds.
// - Backup mode keeps time, ignores bus.
// - Reading control C clears all flags.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`include "rtc_map.svh"
module rtc_timekeeping_core #(
	parameter int SEC_CYC  = `RTC_SEC_CYC,
	parameter int WIN_FAST = `RTC_WIN_FAST_CYC,
	parameter int WIN_SLOW = `RTC_WIN_SLOW_CYC
) (
	input  wire logic               clock_in,
	input  wire logic               srst_in,
	input  wire rtc_pkg::axi_addr_t awaddr_in,
	input  wire logic               awvalid_in,
	output logic                    awready_out,
	input  wire logic [31:0]        wdata_in,
	input  wire logic [3:0]         wstrb_in,
	input  wire logic               wvalid_in,
	output logic                    wready_out,
	output rtc_pkg::resp_t          bresp_out,
	output logic                    bvalid_out,
	input  wire logic               bready_in,
	input  wire rtc_pkg::axi_addr_t araddr_in,
	input  wire logic               arvalid_in,
	output logic                    arready_out,
	output logic [31:0]             rdata_out,
	output rtc_pkg::resp_t          rresp_out,
	output logic                    rvalid_out,
	input  wire logic               rready_in,
	input  wire logic               address_strobe_in,
	input  wire logic               data_strobe_in,
	input  wire logic               reset_n_in,
	input  wire logic               backup_mode_in,
	output logic                    bus_style_out,
	output logic                    update_busy_out,
	output logic                    irq_oe_out
);
	import rtc_pkg::*;

	// Release time for the interrupt pin, used by the checks below.
	localparam int IRQ_REL = `RTC_IRQ_REL_CYC;

	// Every flip-flop of the block lives in this one record.
	typedef struct packed {
		logic [63:0][7:0] ram;    // Whole map; C and D live apart.
		logic             uip;    // Update window in progress.
		logic [16:0]      win;    // Cycles left in the window.
		logic [31:0]      pre;    // One-second prescaler.
		logic             af;     // Alarm flag.
		logic             uf;     // Update-ended flag.
		logic             valid_ram_time_flag;    // Valid RAM and time flag.
		logic             irq;    // Interrupt pin pulled low.
		logic [1:0]       as_q;   // Synchroniser, address strobe.
		logic [1:0]       ds_q;   // Synchroniser, data strobe.
		logic [1:0]       rs_q;   // Synchroniser, reset pin.
		logic [1:0]       bk_q;   // Synchroniser, backup pin.
		logic             style;  // One selects separate strobes.
		logic             aw_got; // Write address held.
		logic             w_got;  // Write data held.
		logic             aw_rdy;
		logic             w_rdy;
		logic             bvalid;
		resp_t            bresp;
		axi_addr_t        waddr;
		byte_t            wdata;
		logic             wen;    // Low byte lane was strobed.
		logic             ar_rdy;
		logic             rvalid;
		resp_t            rresp;
		byte_t            rdata;
		logic [5:0]       rd_idx; // Index of the last read.
	} state_t;

	state_t s;      // Registered state.
	state_t next_s; // Value for the next edge.

	// Decoded controls and events, all driven by the one process.
	logic       bcd;       // Data format select: one means BCD.
	logic       h12;       // Twelve-hour mode.
	logic       bkup;      // Synchronised backup mode.
	logic       div_run;   // Divider chain not held.
	logic       tick;      // One-second tick.
	logic       upd_fire;  // Last cycle of the window, time advances.
	logic       alm_hit;   // Advanced time matches the alarm.
	logic       wr_fire;   // Write completes this cycle.
	logic       wr_go;     // That write reaches the map.
	logic [5:0] wi;        // Word index of the write.
	logic       rd_fire;   // Read address taken.
	logic [5:0] ri;        // Word index of the read.
	logic       rd_c_go;   // Effective read of control C.
	logic       rd_d_go;   // Effective read of control D.
	logic [6:0] mdays;     // Days in the current month.
	logic [6:0] mon_b;     // Month as a count.
	logic [6:0] yr_b;      // Year as a count.
	logic [6:0] h_bin;     // Hour digits as a count.
	logic [6:0] h24;       // Hour on a 0-to-23 scale.
	logic [6:0] h24n;      // Hour after the step.
	logic [6:0] h12n;      // Stepped hour on a 1-to-12 scale.
	byte_t      h_fmt;     // Stepped hour digits.
	logic       day_c;     // Midnight carry.

	// Field steppers; their carries ripple from seconds to years.
	byte_t sec_n;
	byte_t min_n;
	byte_t dow_n;
	byte_t date_n;
	byte_t mon_n;
	byte_t yr_n;
	logic  sec_c;
	logic  min_c;
	logic  date_c;
	logic  mon_c;

	// Every field steps in the format picked by software.
	rtc_field_step u_sec (
		.bcd_in   (bcd),
		.val_in   (s.ram[`RTC_SEC]),
		.lo_in    (7'd0),
		.hi_in    (7'd59),
		.carry_in (1'b1),
		.next_out (sec_n),
		.carry_out(sec_c)
	);
	rtc_field_step u_min (
		.bcd_in   (bcd),
		.val_in   (s.ram[`RTC_MIN]),
		.lo_in    (7'd0),
		.hi_in    (7'd59),
		.carry_in (sec_c),
		.next_out (min_n),
		.carry_out(min_c)
	);
	rtc_field_step u_dow (
		.bcd_in   (bcd),
		.val_in   (s.ram[`RTC_DOW]),
		.lo_in    (7'd1),
		.hi_in    (7'd7),
		.carry_in (day_c),
		.next_out (dow_n),
		.carry_out()
	);
	rtc_field_step u_date (
		.bcd_in   (bcd),
		.val_in   (s.ram[`RTC_DATE]),
		.lo_in    (7'd1),
		.hi_in    (mdays),
		.carry_in (day_c),
		.next_out (date_n),
		.carry_out(date_c)
	);
	rtc_field_step u_mon (
		.bcd_in   (bcd),
		.val_in   (s.ram[`RTC_MONTH]),
		.lo_in    (7'd1),
		.hi_in    (7'd12),
		.carry_in (date_c),
		.next_out (mon_n),
		.carry_out(mon_c)
	);
	rtc_field_step u_yr (
		.bcd_in   (bcd),
		.val_in   (s.ram[`RTC_YEAR]),
		.lo_in    (7'd0),
		.hi_in    (7'd99),
		.carry_in (mon_c),
		.next_out (yr_n),
		.carry_out()
	);

	// Next-state logic for the clock, the flags and both bus halves.
	always_comb begin
		next_s = s;
		bcd = s.ram[`RTC_REG_B][`RTC_B_DM];
		h12 = !s.ram[`RTC_REG_B][`RTC_B_H24];
		bkup = s.bk_q[1];
		// Pins pass two flip-flops before anything reads them.
		next_s.as_q = {s.as_q[0], address_strobe_in};
		next_s.ds_q = {s.ds_q[0], data_strobe_in};
		next_s.rs_q = {s.rs_q[0], reset_n_in};
		next_s.bk_q = {s.bk_q[0], backup_mode_in};
		// The strobe sits low or high during the address phase.
		if (s.as_q[1]) begin
			next_s.style = s.ds_q[1];
		end
		// Month length, with every fourth year a leap year.
		mon_b = to_bin(s.ram[`RTC_MONTH], bcd);
		yr_b = to_bin(s.ram[`RTC_YEAR], bcd);
		case (mon_b)
			7'd2: mdays = (yr_b[1:0] == 2'h0) ? 7'd29 : 7'd28;
			7'd4, 7'd6, 7'd9, 7'd11: mdays = 7'd30;
			default: mdays = 7'd31;
		endcase
		// Hours run on a 0-to-23 scale; the PM bit folds in.
		h_bin = to_bin({1'b0, s.ram[`RTC_HOUR][6:0]}, bcd);
		h24 = h_bin;
		if (h12) begin
			h24 = 7'((h_bin == 7'd12) ? 7'd0 : h_bin);
			h24 = 7'(h24 + (s.ram[`RTC_HOUR][7] ? 7'd12 : 7'd0));
		end
		day_c = min_c && (h24 >= 7'd23);
		h24n = h24;
		if (min_c) begin
			h24n = day_c ? 7'd0 : 7'(h24 + 7'd1);
		end
		h12n = (h24n >= 7'd12) ? 7'(h24n - 7'd12) : h24n;
		if (h12n == 7'd0) begin
			h12n = 7'd12;
		end
		h_fmt = from_bin(h12 ? h12n : h24n, bcd);
		// The dividers run unless the divider field holds them.
		div_run = s.ram[`RTC_REG_A][5:4] != `RTC_DV_HELD;
		tick = div_run && (s.pre == 32'(SEC_CYC - 1));
		next_s.pre = (!div_run || tick) ? 32'h0 : s.pre + 32'h1;
		// The window opens on a tick and closes with the step.
		upd_fire = 1'b0;
		if (s.uip) begin
			if (s.win == 17'h0) begin
				next_s.uip = 1'b0;
				// An inhibited clock is not advanced.
				upd_fire = !s.ram[`RTC_REG_B][`RTC_B_SET];
			end else begin
				next_s.win = s.win - 17'h1;
			end
		end else if (tick && !s.ram[`RTC_REG_B][`RTC_B_SET]) begin
			next_s.uip = 1'b1;
			// The slow crystal needs the longer window.
			if (s.ram[`RTC_REG_A][6:4] == `RTC_DV_SLOW) begin
				next_s.win = 17'(WIN_SLOW - 1);
			end else begin
				next_s.win = 17'(WIN_FAST - 1);
			end
		end
		if (upd_fire) begin
			next_s.ram[`RTC_SEC] = sec_n;
			next_s.ram[`RTC_MIN] = min_n;
			if (min_c) begin
				next_s.ram[`RTC_HOUR] = {h12 && (h24n >= 7'd12), h_fmt[6:0]};
			end
			next_s.ram[`RTC_DOW] = dow_n;
			next_s.ram[`RTC_DATE] = date_n;
			next_s.ram[`RTC_MONTH] = mon_n;
			next_s.ram[`RTC_YEAR] = yr_n;
		end
		// A top pair of ones in an alarm byte matches any value.
		alm_hit = (s.ram[`RTC_SEC_ALM][7:6] == `RTC_WILD ||
			s.ram[`RTC_SEC_ALM] == next_s.ram[`RTC_SEC]) &&
			(s.ram[`RTC_MIN_ALM][7:6] == `RTC_WILD ||
			s.ram[`RTC_MIN_ALM] == next_s.ram[`RTC_MIN]) &&
			(s.ram[`RTC_HOUR_ALM][7:6] == `RTC_WILD ||
			s.ram[`RTC_HOUR_ALM] == next_s.ram[`RTC_HOUR]);
		// Write address and data may arrive in either order.
		if (awvalid_in && s.aw_rdy) begin
			next_s.aw_got = 1'b1;
			next_s.waddr = awaddr_in;
		end
		if (wvalid_in && s.w_rdy) begin
			next_s.w_got = 1'b1;
			next_s.wdata = wdata_in[7:0];
			next_s.wen = wstrb_in[0];
		end
		if (s.bvalid && bready_in) begin
			next_s.bvalid = 1'b0;
		end
		wr_fire = s.aw_got && s.w_got && !s.bvalid;
		wi = s.waddr[7:2];
		// Backup mode answers the bus but changes nothing.
		wr_go = wr_fire && !s.waddr[8] && s.wen && !bkup;
		if (wr_fire) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = s.waddr[8] ? `RTC_RESP_SLVERR : `RTC_RESP_OKAY;
		end
		// A processor write wins over a step in the same cycle.
		if (wr_go) begin
			case (wi)
				`RTC_SEC: next_s.ram[wi] = {1'b0, s.wdata[6:0]};
				`RTC_REG_A: next_s.ram[wi] = {1'b0, s.wdata[6:0]};
				`RTC_REG_C, `RTC_REG_D: next_s.ram[wi] = s.ram[wi];
				default: next_s.ram[wi] = s.wdata;
			endcase
		end
		next_s.aw_rdy = !next_s.aw_got && !next_s.bvalid;
		next_s.w_rdy = !next_s.w_got && !next_s.bvalid;
		// Read side: one read is answered at a time.
		if (s.rvalid && rready_in) begin
			next_s.rvalid = 1'b0;
		end
		rd_fire = arvalid_in && s.ar_rdy;
		ri = araddr_in[7:2];
		rd_c_go = rd_fire && !araddr_in[8] && !bkup && ri == `RTC_REG_C;
		rd_d_go = rd_fire && !araddr_in[8] && !bkup && ri == `RTC_REG_D;
		if (rd_fire) begin
			next_s.rvalid = 1'b1;
			next_s.rd_idx = ri;
			next_s.rresp = araddr_in[8] ? `RTC_RESP_SLVERR : `RTC_RESP_OKAY;
			case (ri)
				`RTC_SEC: next_s.rdata = {1'b0, s.ram[ri][6:0]};
				`RTC_REG_A: next_s.rdata = {s.uip, s.ram[ri][6:0]};
				`RTC_REG_C: next_s.rdata = {s.irq, 1'b0, s.af, s.uf, 4'h0};
				`RTC_REG_D: next_s.rdata = {s.valid_ram_time_flag, 7'h0};
				default: next_s.rdata = s.ram[ri];
			endcase
			if (araddr_in[8] || bkup) begin
				next_s.rdata = 8'h00;
			end
		end
		next_s.ar_rdy = !next_s.rvalid;
		// The valid flag is only ever set, by reading D.
		if (rd_d_go) begin
			next_s.valid_ram_time_flag = 1'b1;
		end
		// Reading C clears the flags; a new event still sets.
		next_s.af = (s.af && !rd_c_go) || (upd_fire && alm_hit);
		next_s.uf = (s.uf && !rd_c_go) || upd_fire;
		// The reset pin drops enables and flags, freeing the pin.
		if (!s.rs_q[1]) begin
			next_s.ram[`RTC_REG_B][6:3] = 4'h0;
			next_s.af = 1'b0;
			next_s.uf = 1'b0;
		end
		next_s.irq = (next_s.af && next_s.ram[`RTC_REG_B][`RTC_B_AIE]) ||
			(next_s.uf && next_s.ram[`RTC_REG_B][`RTC_B_UIE]);
	end

	// One register stage for the whole record.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			s <= '0;
			s.ram[`RTC_REG_A] <= `RTC_A_RST;
			s.ram[`RTC_REG_B] <= `RTC_B_RST;
		end else begin
			s <= next_s;
		end
	end

	// Every output is a flip-flop of the record.
	assign awready_out = s.aw_rdy;
	assign wready_out = s.w_rdy;
	assign bvalid_out = s.bvalid;
	assign bresp_out = s.bresp;
	assign arready_out = s.ar_rdy;
	assign rvalid_out = s.rvalid;
	assign rresp_out = s.rresp;
	assign rdata_out = {24'h0, s.rdata};
	assign bus_style_out = s.style;
	assign update_busy_out = s.uip;
	assign irq_oe_out = s.irq;

	// Checks on the design's own behaviour.
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (srst_in);

	a_style_latch: assert property (s.as_q[1] |=> s.style == $past(s.ds_q[1]))
		else $error("bus style not latched");
	a_sec_msb_zero: assert property (s.rvalid && s.rd_idx == `RTC_SEC
		&& s.rresp == `RTC_RESP_OKAY |-> !s.rdata[7])
		else $error("seconds top bit read as one");
	a_inhibit_hold: assert property (s.ram[`RTC_REG_B][`RTC_B_SET] && !wr_go
		|=> $stable(s.ram[9:0]))
		else $error("time moved while inhibited");
	a_window_len: assert property ($rose(s.uip) |-> s.win ==
		((s.ram[`RTC_REG_A][6:4] == `RTC_DV_SLOW) ? 17'(WIN_SLOW - 1)
		: 17'(WIN_FAST - 1)))
		else $error("update window of wrong length");
	a_window_step: assert property (s.uip && s.win != 17'h0 |=> s.uip
		&& s.win == $past(s.win) - 17'h1)
		else $error("update window cut short");
	a_alarm_set: assert property (upd_fire && alm_hit && s.rs_q[1] |=> s.af)
		else $error("alarm match lost");
	a_alarm_wild: assert property (upd_fire && s.rs_q[1]
		&& s.ram[`RTC_SEC_ALM][7:6] == `RTC_WILD
		&& s.ram[`RTC_MIN_ALM][7:6] == `RTC_WILD
		&& s.ram[`RTC_HOUR_ALM][7:6] == `RTC_WILD |=> s.af)
		else $error("wildcard alarm missed");
	a_vrt_read: assert property (rd_d_go |=> s.valid_ram_time_flag ##1 s.valid_ram_time_flag)
		else $error("valid flag not set by read");
	a_irq_release: assert property (rd_c_go && !upd_fire
		|-> ##[1:IRQ_REL] !s.irq)
		else $error("interrupt not released");
	a_flag_clear: assert property (rd_c_go && !upd_fire |=> !s.af && !s.uf)
		else $error("flags survive read of C");
	a_backup_bus: assert property (bkup && wr_fire && !upd_fire
		|=> $stable(s.ram))
		else $error("write landed in backup mode");
	a_ro_status: assert property (wr_go && wi == `RTC_REG_D && !rd_d_go
		|=> $stable(s.valid_ram_time_flag))
		else $error("write changed status");

	c_update: cover property (upd_fire);
	c_alarm_irq: cover property (upd_fire && alm_hit ##1 s.irq);
	c_read_c: cover property (rd_c_go && s.irq);
	c_style: cover property ($rose(s.style));
endmodule : rtc_timekeeping_core

// ===== tb/rtc_bus_host_model.sv
// Host model that drives the multiplexed bus strobes of the clock core.
module rtc_bus_host_model (
	input  wire logic clock_in,
	input  wire logic style_in,
	output logic      address_strobe_out,
	output logic      data_strobe_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] phase = 4'h0; // Position in a sixteen-cycle bus cycle.

	// Free-running bus cycle counter.
	always_ff @(posedge clock_in) begin
		phase <= phase + 4'h1;
	end

	// The address strobe is high for the first three cycles of each bus cycle.
	assign address_strobe_out = (phase < 4'h3);
	// During the address strobe a strobe-and-direction host keeps the data
	// strobe low and a split-strobe host keeps its read strobe high, so the
	// level there names the style; later it pulses as a real access would.
	assign data_strobe_out = (address_strobe_out || !phase[3]) ?
		style_in : ~style_in;
endmodule : rtc_bus_host_model

// ===== tb/test_rtc_timekeeping_core.sv
// Self-checking bench for the timekeeping core over its register bus.
`include "rtc_map.svh"
module test_rtc_timekeeping_core;
	timeunit 1ns;
	timeprecision 100ps;
	import rtc_pkg::*;
	localparam int SEC = 200;   // Shortened second.
	localparam int WF = 5;      // Shortened fast update window.
	localparam int WS = 9;      // Shortened slow update window.
	localparam int LIMIT = 20000;
	logic clock_in = 1'b0, srst_in = 1'b1;
	axi_addr_t awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, backup = 1'b0, style = 1'b0;
	logic pin_rst_n = 1'b1; // Reset pin of the clock, active low.
	logic [31:0] wdata = '0, rdata;
	logic awready, wready, bvalid, arready, rvalid, as_w, ds_w;
	logic bus_style, busy, irq_oe;
	resp_t bresp, rresp, last_resp;
	int errors = 0, check_count = 0, cycles = 0, w, k, i;
	byte_t d, v;
	// Rows: B, A, sec, min, hour, then expected sec, min, hour.
	byte_t tv [4][8] = '{
		'{8'h02, 8'h00, 8'h3b, 8'h3b, 8'h17, 8'h00, 8'h00, 8'h00},
		'{8'h06, 8'h00, 8'h59, 8'h59, 8'h23, 8'h00, 8'h00, 8'h00},
		'{8'h04, 8'h20, 8'h59, 8'h59, 8'h11, 8'h00, 8'h00, 8'h92},
		'{8'h00, 8'h00, 8'h3b, 8'h3b, 8'h8c, 8'h00, 8'h00, 8'h81}};
	// Rows: alarm sec, min, hour and expected flag byte after one update.
	byte_t av [3][4] = '{'{8'hc0, 8'hc0, 8'hc0, 8'hb0},
		'{8'h11, 8'hc0, 8'hc0, 8'hb0}, '{8'h12, 8'hc0, 8'hc0, 8'h10}};

	rtc_timekeeping_core #(.SEC_CYC(SEC), .WIN_FAST(WF), .WIN_SLOW(WS)) dut_u (
		.clock_in(clock_in), .srst_in(srst_in), .awaddr_in(awaddr),
		.awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata),
		.wstrb_in(4'h1), .wvalid_in(wvalid), .wready_out(wready),
		.bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
		.araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready),
		.rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid),
		.rready_in(rready), .address_strobe_in(as_w), .data_strobe_in(ds_w),
		.reset_n_in(pin_rst_n), .backup_mode_in(backup),
		.bus_style_out(bus_style), .update_busy_out(busy),
		.irq_oe_out(irq_oe));
	rtc_bus_host_model host_u (.clock_in(clock_in), .style_in(style),
		.address_strobe_out(as_w), .data_strobe_out(ds_w));

	// A 40 MHz clock.
	initial begin
		forever #12.5 clock_in = ~clock_in;
	end

	// A hang counts as a mismatch and ends the run.
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			errors++;
			$display("FAIL %0t run did not finish", $time);
			tally_and_finish();
		end
	end

	// Compares a byte result.
	task automatic check_byte(input byte_t got, input byte_t exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t byte %h expected %h", $time, got, exp);
		end
	endtask : check_byte

	// Compares a single flag or pin.
	task automatic check_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t flag %b expected %b", $time, got, exp);
		end
	endtask : check_bit

	// Compares a bus response code.
	task automatic check_resp(input resp_t got, input resp_t exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t response %h expected %h", $time, got, exp);
		end
	endtask : check_resp

	// One write; address and data are each released at their own handshake.
	task automatic wr(input int idx, input byte_t dat);
		logic ha, hw, hb;
		hb = 1'b0;
		@(posedge clock_in);
		awaddr <= axi_addr_t'(idx * 4);
		wdata <= {24'h0, dat};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!hb) begin
			#1;
			ha = awvalid & (awready === 1'b1);
			hw = wvalid & (wready === 1'b1);
			hb = (bvalid === 1'b1);
			last_resp = bresp;
			@(posedge clock_in);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
		end
	endtask : wr

	// One read; the data is taken at the edge where rvalid is seen high.
	task automatic rd(input int idx, output byte_t dat);
		logic ha, hr;
		hr = 1'b0;
		dat = 8'hxx;
		@(posedge clock_in);
		araddr <= axi_addr_t'(idx * 4);
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!hr) begin
			#1;
			ha = arvalid & (arready === 1'b1);
			hr = (rvalid === 1'b1);
			dat = rdata[7:0];
			last_resp = rresp;
			@(posedge clock_in);
			if (ha) arvalid <= 1'b0;
			if (hr) rready <= 1'b0;
		end
	endtask : rd

	// Waits for one update window and returns its length in cycles.
	task automatic wait_tick(output int len);
		len = 0;
		// Busy is looked at just after each edge, where it has settled.
		for (int n = 0; n < 3 * SEC && busy !== 1'b1; n++) begin
			@(posedge clock_in);
			#1;
		end
		while (busy === 1'b1 && len < 100) begin
			len++;
			@(posedge clock_in);
			#1;
		end
		repeat (2) @(posedge clock_in);
	endtask : wait_tick

	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	// Main sequence.
	initial begin
		void'($urandom(70));
		repeat (2) @(posedge clock_in);
		srst_in <= 1'b0;
		rd(10, d);
		check_byte(d, `RTC_A_RST);
		wr(10, 8'h70); // Hold the divider so no update disturbs the checks.
		rd(11, d);
		check_byte(d, `RTC_B_RST);
		rd(13, d);
		check_byte(d, 8'h00);
		rd(13, d);
		check_byte(d, 8'h80);
		wr(13, 8'h00);
		wr(12, 8'hff);
		rd(13, d);
		check_byte(d, 8'h80);
		rd(12, d);
		check_byte(d, 8'h00);
		wr(10, 8'hff);
		rd(10, d);
		check_byte(d, 8'h7f);
		wr(0, 8'hff);
		rd(0, d);
		check_byte(d, 8'h7f);
		$display("test register access done");
		for (k = 0; k < 8; k++) begin
			i = 14 + int'($urandom % 50);
			v = byte_t'($urandom);
			wr(i, v);
			check_resp(last_resp, `RTC_RESP_OKAY);
			rd(i, d);
			check_resp(last_resp, `RTC_RESP_OKAY);
			check_byte(d, v);
		end
		wr(64, 8'h55);
		check_resp(last_resp, `RTC_RESP_SLVERR);
		rd(64, d);
		check_resp(last_resp, `RTC_RESP_SLVERR);
		check_byte(d, 8'h00);
		$display("test memory map done");
		// Time is set with the divider held and updates inhibited.
		wr(10, 8'h70);
		wr(11, 8'h82);
		wr(0, 8'h10);
		wr(10, 8'h00);
		repeat (3 * SEC) @(posedge clock_in);
		rd(0, d);
		check_byte(d, 8'h10);
		$display("test inhibit done");
		for (k = 0; k < 4; k++) begin
			wr(10, 8'h70);
			wr(11, tv[k][0] | 8'h80);
			for (i = 0; i < 3; i++) wr(i * 2, tv[k][i + 2]);
			wr(11, tv[k][0]);
			wr(10, tv[k][1]);
			wait_tick(w);
			check_byte(8'(w), tv[k][1][5] ? 8'(WS) : 8'(WF));
			for (i = 0; i < 3; i++) begin
				rd(i * 2, d);
				check_byte(d, tv[k][i + 5]);
			end
		end
		$display("test increments done");
		for (k = 0; k < 3; k++) begin
			wr(10, 8'h70);
			wr(11, 8'ha2);
			wr(0, 8'h10);
			for (i = 0; i < 3; i++) wr(i * 2 + 1, av[k][i]);
			rd(12, d);
			wr(11, 8'h22);
			wr(10, 8'h00);
			wait_tick(w);
			check_bit(irq_oe, av[k][3][7]);
			rd(12, d);
			check_byte(d, av[k][3]);
			repeat (2) @(posedge clock_in);
			check_bit(irq_oe, 1'b0);
			rd(12, d);
			check_byte(d, 8'h00);
		end
		$display("test alarm done");
		wr(20, 8'h11);
		backup <= 1'b1;
		// The backup pin passes two flip-flops before it counts.
		repeat (2) @(posedge clock_in);
		wr(20, 8'h5a);
		rd(20, d);
		check_byte(d, 8'h00);
		backup <= 1'b0;
		repeat (2) @(posedge clock_in);
		rd(20, d);
		check_byte(d, 8'h11);
		$display("test backup done");
		style <= 1'b1;
		repeat (40) @(posedge clock_in);
		check_bit(bus_style, 1'b1);
		style <= 1'b0;
		repeat (40) @(posedge clock_in);
		check_bit(bus_style, 1'b0);
		$display("test bus style done");
		// The update-ended flag drives the pin; the reset pin frees it.
		wr(11, 8'h12);
		wait_tick(w);
		check_bit(irq_oe, 1'b1);
		pin_rst_n <= 1'b0;
		repeat (4) @(posedge clock_in);
		check_bit(irq_oe, 1'b0);
		pin_rst_n <= 1'b1;
		rd(11, d);
		check_byte(d, 8'h02);
		rd(12, d);
		check_byte(d, 8'h00);
		$display("test pin reset done");
		tally_and_finish();
	end
endmodule : test_rtc_timekeeping_core
